// ==== hdl/asp_map.svh ====
// Register offsets, field positions and reset values of the auto serial port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// Byte offsets
`define ASP_OFF_MODE 8'h00
`define ASP_OFF_STAT 8'h04
`define ASP_OFF_SHIFT 8'h08
`define ASP_OFF_XCTL 8'h0C
`define ASP_OFF_ENDP 8'h10
`define ASP_OFF_DIV 8'h14
// Address bit that selects the buffer window 0x80..0xFC
`define ASP_BUF_BIT 7
// Mode register width, fields follow asp_mode_s
`define ASP_MODE_W 7
// Transfer control fields
`define ASP_XCTL_START 0
`define ASP_XCTL_STOP 1
// Status fields
`define ASP_ST_ACTIVE 0
`define ASP_ST_ERR 1
`define ASP_ST_ERRE 2
`define ASP_ST_STBE 3
`define ASP_ST_BSYE 4
`define ASP_ST_BSYLV 5
`define ASP_ST_CAUSE 8
`define ASP_ST_PTR 16
// Reset values
`define ASP_MODE_RST 7'h00
`define ASP_HS_RST 4'h0
`define ASP_DIV_RST 8'h03
`define ASP_ENDP_RST 5'h1F
// Bus responses
`define ASP_RESP_OK 2'b00
`define ASP_RESP_ERR 2'b10
`endif

// ==== hdl/asp_pkg.sv ====
// Types shared by the auto serial port
package asp_pkg;
  typedef struct packed {
    logic master;
    logic repeat_select;
    logic auto_mode_enable;
    logic receive_enable;
    logic transmit_enable;
    logic bit_order_select;
    logic port_run_enable;
  } asp_mode_s;
  typedef struct packed {
    logic busy_level;
    logic busy_en;
    logic strobe_en;
    logic bit_error_detect_enable;
  } asp_hs_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_SHIFT = 3'b010,
    ST_STROBE = 3'b011,
    ST_NEXT = 3'b100
  } asp_state_e;
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_DONE = 2'b01,
    CAUSE_STOP = 2'b10,
    CAUSE_ERR = 2'b11
  } asp_cause_e;
  typedef enum logic [2:0] {
    SEL_MODE = 3'b000,
    SEL_STAT = 3'b001,
    SEL_SHIFT = 3'b010,
    SEL_XCTL = 3'b011,
    SEL_ENDP = 3'b100,
    SEL_DIV = 3'b101,
    SEL_BUF = 3'b110,
    SEL_NONE = 3'b111
  } asp_sel_e;
endpackage

// ==== hdl/asp_auto_serial_port.sv ====
// Three-wire serial port with one-byte and automatic buffer modes
// Operation
// R1: Exchange bytes over clock, data in and data out lines.
// R2: Master mode drives a strobe and honours a busy input.
// R3: Transmit only: shift out, never capture input data.
// R4: Receive only: capture input data, output held idle.
// R5: Both enabled: shift out and capture in the same byte.
// R6: Automatic bit clear selects one-byte mode, one byte per start.
// R7: Automatic bit set moves a range of bytes via the buffer.
// R8: Repeat clear: transfer the range once, then stop.
// R9: Repeat set: repeat the range until stopped.
// R10: One-byte mode: writing the shift register starts transfer.
// R11: With both enables, that write also starts reception.
// R12: Receive only: software writes dummy data to start each byte.
// R13: Writing one to the start bit launches automatic transfer.
// R14: Completion event after the whole buffer range is moved.
// R15: Stop request finishes the byte, suspends, raises the event.
// R16: Bit error with detection on raises event after the byte.
// R17: Bit error event depends on the detect enable bit.
// R18: Transfer flag reads one while a transfer runs.
// R19: Transfer flag reads zero while idle.
// R20: Run bit starts and stops; order bit selects LSB first.
// R21: Eight bits per byte; buffer holds 32 bytes.
// R22: One-byte mode raises completion at end of the byte.
`include "asp_map.svh"
`timescale 1ns/10ps
`default_nettype none
module asp_auto_serial_port #(
  parameter int BUF_DEPTH = 32,
  parameter int PTR_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic strobe_out_pin,
  input wire logic peer_busy_in_pin,
  output logic xfer_done_pulse,
  output asp_pkg::asp_cause_e xfer_cause
);
  import asp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Address decode, shared by read and write paths
  function automatic asp_sel_e asp_decode(input logic [7:0] a);
    asp_decode = SEL_NONE;
    if (a[`ASP_BUF_BIT]) begin
      asp_decode = SEL_BUF;
    end else begin
      case (a)
        `ASP_OFF_MODE: asp_decode = SEL_MODE;
        `ASP_OFF_STAT: asp_decode = SEL_STAT;
        `ASP_OFF_SHIFT: asp_decode = SEL_SHIFT;
        `ASP_OFF_XCTL: asp_decode = SEL_XCTL;
        `ASP_OFF_ENDP: asp_decode = SEL_ENDP;
        `ASP_OFF_DIV: asp_decode = SEL_DIV;
        default: asp_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Bit presented on the data line for the chosen order
  function automatic logic asp_out_bit(input logic [7:0] v, input logic lsb);
    asp_out_bit = lsb ? v[0] : v[7];
  endfunction

  // Shift one bit in at the end opposite the output end
  function automatic logic [7:0] asp_shift(input logic [7:0] v, input logic b, input logic lsb);
    asp_shift = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic [2:0] sck_sync_reg;
  logic [1:0] si_sync_reg;
  logic [1:0] busy_sync_reg;
  logic aw_have_reg, aw_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  asp_mode_s mode_reg, mode_next;
  asp_hs_s hs_reg, hs_next;
  logic err_reg, err_next;
  logic [7:0] div_reg, div_next;
  logic [PTR_W-1:0] endp_reg, endp_next;
  logic [7:0] buf_reg [BUF_DEPTH];
  logic [7:0] buf_next [BUF_DEPTH];
  asp_state_e st_reg, st_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] rxd_reg, rxd_next;
  logic [7:0] cnt_reg, cnt_next;
  logic sck_reg, sck_next;
  logic so_reg, so_next;
  logic stb_reg, stb_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  logic stop_reg, stop_next;
  logic done_reg, done_next;
  asp_cause_e cause_reg, cause_next;
  asp_sel_e wsel;
  logic wr_fire, wr_ok, one_start, auto_start, stop_wr;
  logic tick, rise, fall, busy_ok, edge_seen;
  logic eng_we;
  logic [7:0] eng_wd;
  logic [PTR_W-1:0] ptr_inc;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops before any logic looks at a pin

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync_reg <= 3'b111;
      si_sync_reg <= 2'b11;
      busy_sync_reg <= 2'b00;
    end else if (ce) begin
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_pin_in};
      si_sync_reg <= {si_sync_reg[0], serial_in_pin};
      busy_sync_reg <= {busy_sync_reg[0], peer_busy_in_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus slave: one write and one read outstanding

  // Ready is gated by the clock enable so nothing is taken while frozen
  assign s_axi_awready = ce & ~aw_have_reg;
  assign s_axi_wready = ce & ~w_have_reg;
  assign s_axi_arready = ce & ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wsel = asp_decode(awaddr_reg);
  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  // Only lane 0 carries fields; other lanes alone change nothing
  assign wr_ok = wr_fire & wstrb_reg;

  // Address and data taken in either order, answered after both
  always_comb begin
    aw_have_next = aw_have_reg;
    awaddr_next = awaddr_reg;
    w_have_next = w_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == SEL_NONE) ? `ASP_RESP_ERR : `ASP_RESP_OK;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = '0;
      rresp_next = `ASP_RESP_OK;
      case (asp_decode(s_axi_araddr))
        SEL_MODE: rdata_next[`ASP_MODE_W-1:0] = mode_reg;
        SEL_STAT: begin
          // R18: active flag reads one while running
          // R19: and zero when idle
          rdata_next[`ASP_ST_ACTIVE] = (st_reg != ST_IDLE);
          rdata_next[`ASP_ST_ERR] = err_reg;
          rdata_next[`ASP_ST_ERRE] = hs_reg.bit_error_detect_enable;
          rdata_next[`ASP_ST_STBE] = hs_reg.strobe_en;
          rdata_next[`ASP_ST_BSYE] = hs_reg.busy_en;
          rdata_next[`ASP_ST_BSYLV] = hs_reg.busy_level;
          rdata_next[`ASP_ST_CAUSE+:2] = cause_reg;
          rdata_next[`ASP_ST_PTR+:PTR_W] = ptr_reg;
        end
        SEL_SHIFT: rdata_next[7:0] = rxd_reg;
        SEL_XCTL: rdata_next[`ASP_XCTL_STOP] = stop_reg;
        SEL_ENDP: rdata_next[PTR_W-1:0] = endp_reg;
        SEL_DIV: rdata_next[7:0] = div_reg;
        SEL_BUF: rdata_next[7:0] = buf_reg[s_axi_araddr[PTR_W+1:2]];
        default: rresp_next = `ASP_RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ASP_RESP_OK;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `ASP_RESP_OK;
    end else if (ce) begin
      aw_have_reg <= aw_have_next;
      awaddr_reg <= awaddr_next;
      w_have_reg <= w_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration, error flag and buffer

  // R1: slave-mode clock edges are seen through the synchroniser
  assign edge_seen = sck_sync_reg[1] ^ sck_sync_reg[2];

  always_comb begin
    mode_next = mode_reg;
    hs_next = hs_reg;
    div_next = div_reg;
    endp_next = endp_reg;
    buf_next = buf_reg;
    err_next = err_reg;
    if (wr_ok) begin
      case (wsel)
        SEL_MODE: mode_next = wdata_reg[`ASP_MODE_W-1:0];
        SEL_STAT: begin
          hs_next.bit_error_detect_enable = wdata_reg[`ASP_ST_ERRE];
          hs_next.strobe_en = wdata_reg[`ASP_ST_STBE];
          hs_next.busy_en = wdata_reg[`ASP_ST_BSYE];
          hs_next.busy_level = wdata_reg[`ASP_ST_BSYLV];
          // Write one clears the error flag
          if (wdata_reg[`ASP_ST_ERR]) begin
            err_next = 1'b0;
          end
        end
        SEL_ENDP: endp_next = wdata_reg[PTR_W-1:0];
        SEL_DIV: div_next = wdata_reg[7:0];
        SEL_BUF: buf_next[awaddr_reg[PTR_W+1:2]] = wdata_reg[7:0];
        default: ;
      endcase
    end
    // R16: a slave clock edge outside a byte is a bit shift error
    if (mode_reg.port_run_enable && !mode_reg.master && edge_seen && st_reg != ST_SHIFT) begin
      err_next = 1'b1;
    end
    // R7: received bytes land in the buffer, winning over a bus write
    if (eng_we) begin
      buf_next[ptr_reg] = eng_wd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `ASP_MODE_RST;
      hs_reg <= `ASP_HS_RST;
      div_reg <= `ASP_DIV_RST;
      endp_reg <= `ASP_ENDP_RST;
      err_reg <= 1'b0;
    end else if (ce) begin
      mode_reg <= mode_next;
      hs_reg <= hs_next;
      div_reg <= div_next;
      endp_reg <= endp_next;
      err_reg <= err_next;
    end
  end

  // Buffer is data only and needs no reset
  always_ff @(posedge aclk) begin
    if (ce) begin
      buf_reg <= buf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transfer engine

  // R10: shift register write starts a byte
  // R11: the same write starts reception when both are enabled
  // R6: only in one-byte mode and only from idle
  assign one_start = wr_ok && wsel == SEL_SHIFT && mode_reg.port_run_enable && !mode_reg.auto_mode_enable &&
                     st_reg == ST_IDLE && (mode_reg.transmit_enable || mode_reg.receive_enable);
  // R13: start bit launches the automatic range
  assign auto_start = wr_ok && wsel == SEL_XCTL && wdata_reg[`ASP_XCTL_START] && mode_reg.port_run_enable &&
                      mode_reg.auto_mode_enable && st_reg == ST_IDLE;
  assign stop_wr = wr_ok && wsel == SEL_XCTL && wdata_reg[`ASP_XCTL_STOP] && st_reg != ST_IDLE;
  assign tick = (cnt_reg == div_reg);
  assign rise = mode_reg.master ? (tick & ~sck_reg) : (sck_sync_reg[1] & ~sck_sync_reg[2]);
  assign fall = mode_reg.master ? (tick & sck_reg) : (~sck_sync_reg[1] & sck_sync_reg[2]);
  // R2: peer holds off the next byte while busy is at its active level
  assign busy_ok = ~(hs_reg.busy_en & (busy_sync_reg[1] == hs_reg.busy_level));
  assign ptr_inc = ptr_reg + PTR_W'(1);

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rxd_next = rxd_reg;
    cnt_next = cnt_reg;
    sck_next = sck_reg;
    ptr_next = ptr_reg;
    done_next = 1'b0;
    cause_next = cause_reg;
    eng_we = 1'b0;
    eng_wd = rx_reg;
    case (st_reg)
      ST_IDLE: begin
        if (one_start || auto_start) begin
          // R12: in receive only the written value is a dummy
          tx_next = one_start ? wdata_reg[7:0] : buf_reg[0];
          ptr_next = '0;
          st_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!mode_reg.master || busy_ok) begin
          st_next = ST_SHIFT;
          bit_next = 3'd0;
          cnt_next = 8'h00;
          sck_next = 1'b1;
        end
      end
      ST_SHIFT: begin
        if (mode_reg.master) begin
          cnt_next = tick ? 8'h00 : cnt_reg + 8'h01;
          sck_next = tick ? ~sck_reg : sck_reg;
        end
        // R1: sample on the rising edge, eight per byte
        if (rise) begin
          bit_next = bit_reg + 3'd1;
          // R3: capture only with receive enabled
          if (mode_reg.receive_enable) begin
            rx_next = asp_shift(rx_reg, si_sync_reg[1], mode_reg.bit_order_select);
          end
          // R21: byte ends at the eighth edge
          if (bit_reg == 3'd7) begin
            cnt_next = 8'h00;
            st_next = (mode_reg.master && hs_reg.strobe_en) ? ST_STROBE : ST_NEXT;
            if (mode_reg.receive_enable) begin
              rxd_next = rx_next;
              eng_wd = rx_next;
              eng_we = mode_reg.auto_mode_enable;
            end
          end
        end
        // R20: advance the output in the selected bit order
        if (fall && bit_reg != 3'd0) begin
          tx_next = asp_shift(tx_reg, 1'b0, mode_reg.bit_order_select);
        end
      end
      ST_STROBE: begin
        // R2: strobe stands one clock half period
        cnt_next = cnt_reg + 8'h01;
        if (tick) begin
          st_next = ST_NEXT;
        end
      end
      ST_NEXT: begin
        st_next = ST_IDLE;
        done_next = 1'b1;
        cause_next = CAUSE_DONE;
        // R17: error only counts with detection enabled
        if (err_reg && hs_reg.bit_error_detect_enable) begin
          // R16: raised now that the byte has finished
          cause_next = CAUSE_ERR;
        end else if (!mode_reg.auto_mode_enable) begin
          // R22: one-byte completion
          cause_next = CAUSE_DONE;
        end else if (stop_reg) begin
          // R15: suspended after the current byte
          cause_next = CAUSE_STOP;
        end else if (ptr_reg == endp_reg) begin
          // R9: repeat restarts the range
          if (mode_reg.repeat_select) begin
            done_next = 1'b0;
            ptr_next = '0;
            tx_next = buf_reg[0];
            st_next = ST_WAIT;
          end
          // R8: otherwise R14: range complete
        end else begin
          // R7: next byte of the range without software help
          done_next = 1'b0;
          ptr_next = ptr_inc;
          tx_next = buf_reg[ptr_inc];
          st_next = ST_WAIT;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // R20: clearing the run bit stops at once
    if (!mode_reg.port_run_enable) begin
      st_next = ST_IDLE;
      sck_next = 1'b1;
    end
  end

  // Stop request lives until the engine goes idle; going idle wins over a new request
  assign stop_next = (stop_reg | stop_wr) & (st_next != ST_IDLE);
  // R4: receive only keeps the data line idle high
  // R5: with transmit enabled the line carries data while receiving
  assign so_next = (st_reg == ST_SHIFT && st_next != ST_SHIFT) ? so_reg :
                   (st_next == ST_SHIFT && mode_reg.transmit_enable) ?
                   asp_out_bit(tx_next, mode_reg.bit_order_select) : 1'b1;
  assign stb_next = (st_next == ST_STROBE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_IDLE;
      bit_reg <= 3'd0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      rxd_reg <= 8'h00;
      cnt_reg <= 8'h00;
      sck_reg <= 1'b1;
      so_reg <= 1'b1;
      stb_reg <= 1'b0;
      ptr_reg <= '0;
      stop_reg <= 1'b0;
      done_reg <= 1'b0;
      cause_reg <= CAUSE_NONE;
    end else if (ce) begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rxd_reg <= rxd_next;
      cnt_reg <= cnt_next;
      sck_reg <= sck_next;
      so_reg <= so_next;
      stb_reg <= stb_next;
      ptr_reg <= ptr_next;
      stop_reg <= stop_next;
      done_reg <= done_next;
      cause_reg <= cause_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pins and events

  // Master drives the clock pin; a slave only listens to it
  assign serial_clock_pin_out = sck_reg;
  assign serial_clock_pin_oe = mode_reg.master & mode_reg.port_run_enable;
  assign serial_out_pin = so_reg;
  assign strobe_out_pin = stb_reg;
  assign xfer_done_pulse = done_reg;
  assign xfer_cause = cause_reg;
endmodule
`default_nettype wire

// ==== verification/asp_peer_model.sv ====
// Serial peripheral model on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module asp_peer_model (
  input wire logic sck,
  input wire logic sdo,
  input wire logic sel,
  input wire logic [7:0] tx_byte,
  output logic sdi,
  output logic [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  int bits = 0;
  ////////////////////////////////////////
  // capture on rise
  // Sample data on each rising clock edge, eight to a byte
  always @(posedge sck) begin
    if (sel) begin
      rx_byte <= {rx_byte[6:0], sdo};
      bits <= (bits == 7) ? 0 : bits + 1;
    end
  end
  // shift on fall
  // Load at first fall; refill inverted so stale bits look wrong
  always @(negedge sck) begin
    if (sel) begin
      if (bits == 0) sh <= tx_byte;
      else sh <= {sh[6:0], ~sh[0]};
    end
  end
  assign sdi = sel ? sh[7] : ~sh[7];
endmodule
`default_nettype wire

// ==== verification/asp_auto_serial_port_assertions.sv ====
// Concurrent checks on the auto serial port pins
`timescale 1ns/10ps
`default_nettype none
module asp_auto_serial_port_assertions
  import asp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic serial_clock_pin_out,
  input wire logic serial_out_pin,
  input wire logic strobe_out_pin,
  input wire logic xfer_done_pulse,
  input wire asp_cause_e xfer_cause
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Checks assume the reset divider, half period of four cycles
  property p_done_one;
    xfer_done_pulse |=> !xfer_done_pulse;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done pulse too long");
  property p_cause_set;
    xfer_done_pulse |=> xfer_cause != CAUSE_NONE;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("event without cause");
  property p_clk_low;
    $fell(serial_clock_pin_out) |=> !serial_clock_pin_out [*3];
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low phase short");
  property p_clk_high;
    $rose(serial_clock_pin_out) |=> serial_clock_pin_out [*3];
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high phase short");
  property p_so_steady;
    $rose(serial_clock_pin_out) |-> $stable(serial_out_pin);
  endproperty
  a_so_steady: assert property (p_so_steady) else $error("data moved at sample edge");
  property p_stb_idle;
    strobe_out_pin |-> serial_clock_pin_out;
  endproperty
  a_stb_idle: assert property (p_stb_idle) else $error("strobe inside a byte");
  property p_stb_len;
    $rose(strobe_out_pin) |-> strobe_out_pin [*4] ##1 !strobe_out_pin;
  endproperty
  a_stb_len: assert property (p_stb_len) else $error("strobe length wrong");
  property p_done_idle;
    xfer_done_pulse |-> serial_clock_pin_out && !strobe_out_pin;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done before byte end");
  property p_rst;
    $rose(aresetn) |-> serial_clock_pin_out && serial_out_pin && !xfer_done_pulse && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  c_done: cover property (xfer_done_pulse ##1 xfer_cause == CAUSE_DONE);
  c_stop: cover property (xfer_done_pulse ##1 xfer_cause == CAUSE_STOP);
  c_err: cover property (xfer_done_pulse ##1 xfer_cause == CAUSE_ERR);
endmodule
bind asp_auto_serial_port asp_auto_serial_port_assertions asp_auto_serial_port_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_out_pin(serial_out_pin),
  .strobe_out_pin(strobe_out_pin), .xfer_done_pulse(xfer_done_pulse), .xfer_cause(xfer_cause)
);
`default_nettype wire

// ==== verification/asp_auto_serial_port_test.sv ====
// Self-checking bench for the auto serial port
`timescale 1ns/10ps
`default_nettype none
module asp_auto_serial_port_test;
  import asp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awa = 0;
  logic [7:0] ara = 0;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sck_in = 1, busy = 0;
  logic awr, wrdy, bv, arr, rv, sdi, sck, oe, sdo, stb, done;
  logic [1:0] br, rr, resp;
  logic [31:0] rdat;
  logic [7:0] ptx = 0, prx;
  asp_cause_e cause;
  int err_count = 0, checks_done = 0, n_done = 0, n_ref = 0, stb_seen = 0;
  always #25 aclk = ~aclk;
  asp_auto_serial_port asp_auto_serial_port_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck), .serial_clock_pin_oe(oe),
    .serial_in_pin(sdi), .serial_out_pin(sdo), .strobe_out_pin(stb),
    .peer_busy_in_pin(busy), .xfer_done_pulse(done), .xfer_cause(cause)
  );
  asp_peer_model asp_peer_model_inst (
    .sck(sck), .sdo(sdo), .sel(oe), .tx_byte(ptx), .sdi(sdi), .rx_byte(prx)
  );
  ////////////////////////////////////////
  // Tally events so a pulse between waits is never lost
  always @(posedge aclk) begin
    if (done === 1'b1) n_done++;
    if (stb === 1'b1) stb_seen = 1;
  end
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write: AW and W together, each dropped when taken
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    fork
      begin
        do @(posedge aclk); while (awr !== 1'b1);
        awv <= 0;
      end
      begin
        do @(posedge aclk); while (wrdy !== 1'b1);
        wv <= 0;
      end
    join
    while (bv !== 1'b1) @(posedge aclk);
    chk(br, 2'b00);
    bry <= 0;
  endtask
  // Read a register, compare masked low byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 0;
    while (rv !== 1'b1) @(posedge aclk);
    resp = rr;
    rry <= 0;
    chk(rdat[7:0] & m, e);
  endtask
  task automatic wait_done(input asp_cause_e c);
    while (n_done == n_ref) @(posedge aclk);
    n_ref++;
    @(posedge aclk);
    chk(cause, c);
  endtask
  // Slave clock, 400 ns period, idle high
  task automatic sclk(input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      sck_in <= 0;
      repeat (4) @(posedge aclk);
      sck_in <= 1;
    end
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rd_chk(8'h00, 8'hFF, 8'h00);
    rd_chk(8'h14, 8'hFF, 8'h03);
    rd_chk(8'h10, 8'hFF, 8'h1F);
    bus_wr(8'hFC, 8'h6E);
    rd_chk(8'hFC, 8'hFF, 8'h6E);
    rd_chk(8'h40, 8'hFF, 8'h00);
    chk(resp, 2'b10);
  endtask
  task automatic t_byte;
    ptx <= 8'hA5;
    bus_wr(8'h00, 8'h4D);
    bus_wr(8'h08, 8'h3C);
    rd_chk(8'h04, 8'h01, 8'h01);
    wait_done(CAUSE_DONE);
    chk(prx, 8'h3C);
    rd_chk(8'h08, 8'hFF, 8'hA5);
    rd_chk(8'h04, 8'h01, 8'h00);
    chk(n_done, n_ref);
  endtask
  task automatic t_tx_rx_only;
    ptx <= 8'h0F;
    bus_wr(8'h00, 8'h47);
    bus_wr(8'h08, 8'h01);
    wait_done(CAUSE_DONE);
    chk(prx, 8'h80);
    rd_chk(8'h08, 8'hFF, 8'hA5);
    ptx <= 8'h5A;
    bus_wr(8'h00, 8'h49);
    bus_wr(8'h08, 8'h00);
    wait_done(CAUSE_DONE);
    rd_chk(8'h08, 8'hFF, 8'h5A);
    chk(prx, 8'hFF);
  endtask
  task automatic t_auto;
    ptx <= 8'hC3;
    for (int i = 0; i < 5; i++) bus_wr(8'h80 + 8'(4 * i), 8'h11 * (i + 1));
    bus_wr(8'h10, 8'h03);
    bus_wr(8'h00, 8'h5D);
    bus_wr(8'h0C, 8'h01);
    wait_done(CAUSE_DONE);
    chk(prx, 8'h44);
    rd_chk(8'h80, 8'hFF, 8'hC3);
    rd_chk(8'h90, 8'hFF, 8'h55);
    rd_chk(8'h04, 8'h01, 8'h00);
    bus_wr(8'h00, 8'h7D);
    bus_wr(8'h0C, 8'h01);
    repeat (400) @(posedge aclk);
    chk(n_done, n_ref);
    bus_wr(8'h0C, 8'h02);
    wait_done(CAUSE_STOP);
  endtask
  task automatic t_busy;
    bus_wr(8'h00, 8'h4D);
    bus_wr(8'h04, 8'h38);
    busy <= 1;
    bus_wr(8'h08, 8'h99);
    repeat (200) @(posedge aclk);
    chk(n_done, n_ref);
    busy <= 0;
    wait_done(CAUSE_DONE);
    chk(stb_seen, 1);
  endtask
  // Stray slave clock sets the error; reported only with detection on
  task automatic t_err;
    bus_wr(8'h00, 8'h09);
    bus_wr(8'h04, 8'h00);
    sclk(1);
    rd_chk(8'h04, 8'h02, 8'h02);
    bus_wr(8'h08, 8'h00);
    sclk(8);
    wait_done(CAUSE_DONE);
    bus_wr(8'h04, 8'h04);
    bus_wr(8'h08, 8'h00);
    sclk(8);
    wait_done(CAUSE_ERR);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_byte();
    t_tx_rx_only();
    t_auto();
    t_busy();
    t_err();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
